// >>> hw/pmr_cfg.svh
/*
  constants of the margin, divider and frequency command registers.
  assumes inclusion by every file that decodes command codes or defaults.
*/
`ifndef PMR_CFG_SVH
`define PMR_CFG_SVH

// ==========================================
// command codes
`define PMR_CMD_MLOW 8'h26
`define PMR_CMD_SCALE 8'h29
`define PMR_CMD_FREQ 8'h33

// ==========================================
// power-up defaults
`define PMR_MLOW_RST 16'h0451
`define PMR_SCALE_RST 16'hb900
`define PMR_FREQ_RST 16'h2813

// ==========================================
// field layout
`define PMR_MLOW_RW_MSB 14
`define PMR_SCALE_FIX 6'h2e
`define PMR_SCALE_M_MSB 9
`define PMR_SCALE_MAX 10'h200
`define PMR_SCALE_SHIFT 9
`define PMR_FREQ_FIX 10'h0a0
`define PMR_FREQ_M_MSB 10
`define PMR_FREQ_RW_MSB 5

// ==========================================
// reference in output units of 2^-10 v
`define PMR_VREF_MV 600
`define PMR_LIN_ONE 1024
`define PMR_MV_PER_V 1000
`define PMR_VREF_CODE (`PMR_VREF_MV * `PMR_LIN_ONE / `PMR_MV_PER_V)

`endif

// >>> hw/pmr_pkg.sv
/*
  types shared by the margin and frequency register bank.
  assumes nothing of its surroundings.
*/
package pmr_pkg;
  typedef logic [15:0] pmr_word_type;
  typedef logic [7:0] pmr_code_type;
  // store sequence, gray along the path
  typedef enum logic [1:0] {
    PMR_ST_IDLE = 2'b00,
    PMR_ST_MLOW = 2'b01,
    PMR_ST_SCALE = 2'b11,
    PMR_ST_FREQ = 2'b10
  } pmr_store_type;
endpackage

// >>> hw/pmr_calc_if.sv
/*
  interface between the register bank and its two calculators.
  assumes all three sit on one clock; the signals are combinational.
*/
`timescale 1ns/100ps
interface pmr_calc_if;
  logic [10:0] freq_wr_m;
  logic [5:0] freq_rounded;
  logic signed [16:0] tgt_sum;
  logic [9:0] scale_m;
  logic [15:0] fb_target;
  logic out_range;

  modport bank_mp (
    output freq_wr_m, tgt_sum, scale_m,
    input freq_rounded, fb_target, out_range
  );
  modport freq_mp (
    input freq_wr_m,
    output freq_rounded
  );
  modport marg_mp (
    input tgt_sum, scale_m,
    output fb_target, out_range
  );
endinterface

// >>> hw/pmr_freq_round.sv
/*
  rounds a written frequency mantissa to a supported step.
  assumes the mantissa counts 32 khz units under the fixed exponent.
*/
`timescale 1ns/100ps
module pmr_freq_round (
  // calculator side
  pmr_calc_if.freq_mp calc
);
  import pmr_pkg::*;

  localparam int NSTEP = 14;
  // 200..900 khz, 1.0..1.8 mhz, 1.9 mhz in 32 khz units
  localparam logic [5:0] STEP [NSTEP] = '{
    6'h07, 6'h0a, 6'h0d, 6'h10, 6'h13, 6'h16, 6'h19,
    6'h1d, 6'h20, 6'h26, 6'h2c, 6'h32, 6'h39, 6'h3c
  };

  logic [NSTEP-1:0] fits;

  // ==========================================
  // step comparison
  genvar gi;
  generate
    for (gi = 0; gi < NSTEP; gi++) begin : g_step
      assign fits[gi] = calc.freq_wr_m <= {5'h00, STEP[gi]};
    end
  endgenerate

  // ==========================================
  // lowest step at or above the value
  always_comb begin
    calc.freq_rounded = STEP[NSTEP-1];
    for (int i = NSTEP - 1; i >= 0; i--) begin
      if (fits[i]) begin
        calc.freq_rounded = STEP[i];
      end
    end
  end
endmodule

// >>> hw/pmr_margin_check.sv
/*
  scales a margin target to the feedback node and clamps it to +-25 %.
  assumes the target sum is in 2^-10 v units and the divider mantissa in 2^-9.
*/
`timescale 1ns/100ps
`include "pmr_cfg.svh"
module pmr_margin_check (
  // calculator side
  pmr_calc_if.marg_mp calc
);
  import pmr_pkg::*;

  localparam logic signed [19:0] REF = 20'(`PMR_VREF_CODE);
  localparam logic signed [19:0] LIM_HI = REF + (REF >>> 2);
  localparam logic signed [19:0] LIM_LO = REF - (REF >>> 2);

  logic signed [27:0] prod;
  logic signed [19:0] fb;

  // ==========================================
  // scaling and limit
  always_comb begin
    prod = 28'(calc.tgt_sum * $signed({1'b0, calc.scale_m}));
    fb = 20'(prod >>> `PMR_SCALE_SHIFT);
    calc.out_range = 1'b0;
    calc.fb_target = 16'(fb);
    if (fb > LIM_HI) begin
      calc.out_range = 1'b1;
      calc.fb_target = 16'(LIM_HI);
    end else if (fb < LIM_LO) begin
      calc.out_range = 1'b1;
      calc.fb_target = 16'(LIM_LO);
    end
  end
endmodule

// >>> hw/pmr_regs.sv
/*
  margin-low, divider ratio and switching frequency command registers.
  assumes a decoded command port on clk_sys, operation and trim from logic
  on the same clock, and a non-volatile store that takes one word per cycle.
*/
// Function
// - margin-low target at command 26h
// - store commands copy all three registers
// - margin output is target plus trim
// - margin-low write takes no range check
// - out-of-range margin sets cml flags
// - out-of-range margin clamps to nearer limit
// - restore commands reload power-up defaults
// - margin-low 16 bits, bit 15 read-only
// - divider exponent fixed, mantissa default 256
// - divider mantissa accepts up to 512
// - voltage values scale by divider ratio
// - frequency 200 khz-1.9 mhz, round up
// - fourteen supported steps, default 600 khz
// - frequency word: 5-bit exponent, 11-bit mantissa
// - exponent five, only six mantissa bits writable
`timescale 1ns/100ps
`include "pmr_cfg.svh"
module pmr_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire pmr_pkg::pmr_code_type cmd_code,
  input wire pmr_pkg::pmr_word_type cmd_wdata,
  output pmr_pkg::pmr_word_type rd_data,
  output logic rd_valid,
  output logic cmd_unsupported,
  // store and restore
  input wire logic store_req,
  input wire logic restore_req,
  output logic store_busy,
  output logic nvm_wr,
  output pmr_pkg::pmr_code_type nvm_code,
  output pmr_pkg::pmr_word_type nvm_data,
  // margin control
  input wire pmr_pkg::pmr_word_type vout_trim,
  input wire logic margin_low_req,
  input wire logic margin_exit,
  input wire logic clear_faults,
  output logic margin_active,
  output pmr_pkg::pmr_word_type vout_fb_target,
  output logic cml_event,
  output logic status_cml,
  output logic cml_ivd,
  // register contents
  output pmr_pkg::pmr_word_type margin_low_target,
  output pmr_pkg::pmr_word_type feedback_divider_ratio,
  output pmr_pkg::pmr_word_type switching_frequency_select
);
  import pmr_pkg::*;

  pmr_word_type mlow_q;
  pmr_word_type scale_q;
  pmr_word_type freq_q;
  pmr_word_type rd_data_q;
  logic rd_valid_q;
  logic unsup_q;
  pmr_store_type st_q;
  logic busy_q;
  logic nvm_wr_q;
  pmr_code_type nvm_code_q;
  pmr_word_type nvm_data_q;
  logic margin_active_q;
  pmr_word_type fb_target_q;
  logic cml_event_q;
  logic status_cml_q;
  logic cml_ivd_q;
  logic wr_mlow;
  logic wr_scale;
  logic wr_freq;
  logic mapped;
  logic [9:0] scale_m_d;

  pmr_calc_if calc ();

  // ==========================================
  // calculators
  pmr_freq_round u_freq (
    .calc (calc.freq_mp)
  );

  pmr_margin_check u_marg (
    .calc (calc.marg_mp)
  );

  assign calc.freq_wr_m = cmd_wdata[`PMR_FREQ_M_MSB:0];
  assign calc.scale_m = scale_q[`PMR_SCALE_M_MSB:0];
  assign calc.tgt_sum = $signed({mlow_q[15], mlow_q}) +
    $signed({vout_trim[15], vout_trim});

  // ==========================================
  // command decode
  always_comb begin
    mapped = (cmd_code == `PMR_CMD_MLOW) || (cmd_code == `PMR_CMD_SCALE) ||
             (cmd_code == `PMR_CMD_FREQ);
    wr_mlow = cmd_valid && cmd_write && (cmd_code == `PMR_CMD_MLOW);
    wr_scale = cmd_valid && cmd_write && (cmd_code == `PMR_CMD_SCALE);
    wr_freq = cmd_valid && cmd_write && (cmd_code == `PMR_CMD_FREQ);
    if (cmd_wdata[`PMR_SCALE_M_MSB:0] > `PMR_SCALE_MAX) begin
      scale_m_d = `PMR_SCALE_MAX;
    end else begin
      scale_m_d = cmd_wdata[`PMR_SCALE_M_MSB:0];
    end
  end

  // ==========================================
  // margin-low target
  always_ff @(posedge clk_sys) begin
    if (!rst_n || restore_req) begin
      mlow_q <= `PMR_MLOW_RST;
    end else if (wr_mlow) begin
      mlow_q <= {1'b0, cmd_wdata[`PMR_MLOW_RW_MSB:0]};
    end
  end

  // ==========================================
  // feedback divider ratio
  always_ff @(posedge clk_sys) begin
    if (!rst_n || restore_req) begin
      scale_q <= `PMR_SCALE_RST;
    end else if (wr_scale) begin
      scale_q <= {`PMR_SCALE_FIX, scale_m_d};
    end
  end

  // ==========================================
  // switching frequency
  always_ff @(posedge clk_sys) begin
    if (!rst_n || restore_req) begin
      freq_q <= `PMR_FREQ_RST;
    end else if (wr_freq) begin
      freq_q <= {`PMR_FREQ_FIX, calc.freq_rounded};
    end
  end

  // ==========================================
  // read answer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
      unsup_q <= 1'b0;
    end else begin
      rd_valid_q <= cmd_valid && !cmd_write && mapped;
      unsup_q <= cmd_valid && !mapped;
      if (cmd_valid && !cmd_write) begin
        case (cmd_code)
          `PMR_CMD_MLOW: rd_data_q <= mlow_q;
          `PMR_CMD_SCALE: rd_data_q <= scale_q;
          `PMR_CMD_FREQ: rd_data_q <= freq_q;
          default: rd_data_q <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================
  // store sequence, one word per cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= PMR_ST_IDLE;
      busy_q <= 1'b0;
      nvm_wr_q <= 1'b0;
      nvm_code_q <= 8'h00;
      nvm_data_q <= 16'h0000;
    end else begin
      nvm_wr_q <= 1'b0;
      case (st_q)
        PMR_ST_IDLE: begin
          if (store_req) begin
            st_q <= PMR_ST_MLOW;
            busy_q <= 1'b1;
          end
        end
        PMR_ST_MLOW: begin
          nvm_wr_q <= 1'b1;
          nvm_code_q <= `PMR_CMD_MLOW;
          nvm_data_q <= mlow_q;
          st_q <= PMR_ST_SCALE;
        end
        PMR_ST_SCALE: begin
          nvm_wr_q <= 1'b1;
          nvm_code_q <= `PMR_CMD_SCALE;
          nvm_data_q <= scale_q;
          st_q <= PMR_ST_FREQ;
        end
        PMR_ST_FREQ: begin
          nvm_wr_q <= 1'b1;
          nvm_code_q <= `PMR_CMD_FREQ;
          nvm_data_q <= freq_q;
          st_q <= PMR_ST_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          st_q <= PMR_ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // margin-low apply and check
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      margin_active_q <= 1'b0;
      fb_target_q <= 16'h0000;
      cml_event_q <= 1'b0;
    end else begin
      cml_event_q <= 1'b0;
      if (margin_low_req) begin
        margin_active_q <= 1'b1;
        fb_target_q <= calc.fb_target;
        cml_event_q <= calc.out_range;
      end else if (margin_exit) begin
        margin_active_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // sticky fault flags, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_cml_q <= 1'b0;
      cml_ivd_q <= 1'b0;
    end else if (margin_low_req && calc.out_range) begin
      status_cml_q <= 1'b1;
      cml_ivd_q <= 1'b1;
    end else if (clear_faults) begin
      status_cml_q <= 1'b0;
      cml_ivd_q <= 1'b0;
    end
  end

  // ==========================================
  // outputs
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign cmd_unsupported = unsup_q;
  assign store_busy = busy_q;
  assign nvm_wr = nvm_wr_q;
  assign nvm_code = nvm_code_q;
  assign nvm_data = nvm_data_q;
  assign margin_active = margin_active_q;
  assign vout_fb_target = fb_target_q;
  assign cml_event = cml_event_q;
  assign status_cml = status_cml_q;
  assign cml_ivd = cml_ivd_q;
  assign margin_low_target = mlow_q;
  assign feedback_divider_ratio = scale_q;
  assign switching_frequency_select = freq_q;

  // ==========================================
  // checks
  a_mlow_sign_ro: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_mlow && !restore_req |=> mlow_q == {1'b0, $past(cmd_wdata[14:0])})
    else $error("margin-low write not stored with bit 15 clear");

  a_mlow_no_check: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_mlow && !restore_req && !margin_low_req && !clear_faults
    |=> !cml_event_q && $stable(status_cml_q))
    else $error("margin-low write raised a range fault");

  a_restore_defaults: assert property (@(posedge clk_sys) disable iff (!rst_n)
    restore_req |=> mlow_q == 16'h0451 && scale_q == 16'hb900 && freq_q == 16'h2813)
    else $error("restore did not reload defaults");

  a_scale_exp_fix: assert property (@(posedge clk_sys) disable iff (!rst_n)
    scale_q[15:10] == 6'h2e && scale_q[9:0] <= 10'h200)
    else $error("divider exponent or mantissa out of form");

  a_scale_cap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_scale && !restore_req && cmd_wdata[9:0] > 10'h200 |=> scale_q[9:0] == 10'h200)
    else $error("divider mantissa not capped at 512");

  a_freq_form: assert property (@(posedge clk_sys) disable iff (!rst_n)
    freq_q[15:6] == 10'h0a0 && freq_q[5:0] >= 6'h07 && freq_q[5:0] <= 6'h3c)
    else $error("frequency word out of form");

  a_freq_round_up: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_freq && !restore_req && cmd_wdata[10:0] <= 11'h03c
    |=> {5'h00, freq_q[5:0]} >= $past(cmd_wdata[10:0]))
    else $error("frequency write rounded down");

  a_freq_clamp_hi: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_freq && !restore_req && cmd_wdata[10:0] > 11'h03c |=> freq_q[5:0] == 6'h3c)
    else $error("high frequency write not clamped");

  a_store_three: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == PMR_ST_IDLE && store_req |=> ##1 nvm_wr_q && nvm_code_q == 8'h26
    ##1 nvm_wr_q && nvm_code_q == 8'h29 ##1 nvm_wr_q && nvm_code_q == 8'h33)
    else $error("store sequence did not copy three words");

  a_range_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    margin_low_req && calc.out_range |=> status_cml_q && cml_ivd_q && cml_event_q)
    else $error("out-of-range margin did not set flags");

  a_clamp_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    margin_low_req && calc.out_range |=> fb_target_q == 16'h02ff || fb_target_q == 16'h01cd)
    else $error("out-of-range margin not clamped to a limit");

  a_margin_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
    margin_low_req |=> margin_active_q ##0 fb_target_q == $past(calc.fb_target))
    else $error("margin request not applied");

  a_margin_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    margin_exit && !margin_low_req |=> !margin_active_q)
    else $error("margin exit not applied");

  a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    margin_low_req && calc.out_range && clear_faults |=> status_cml_q && cml_ivd_q)
    else $error("fault clear beat a new range fault");

  a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clear_faults && !(margin_low_req && calc.out_range) |=> !status_cml_q && !cml_ivd_q)
    else $error("fault clear did not clear flags");

  a_store_busy_span: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == PMR_ST_IDLE && store_req |=> busy_q [*3] ##1 !busy_q)
    else $error("store busy span wrong");

  a_store_no_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q != PMR_ST_IDLE |=> st_q != PMR_ST_MLOW)
    else $error("store request taken while busy");

  a_store_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == PMR_ST_MLOW |=> nvm_data_q == $past(mlow_q))
    else $error("stored margin word differs from register");

  a_unsup_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid && !mapped |=> unsup_q && !rd_valid_q)
    else $error("unmapped command not flagged");

  a_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid && !cmd_write && cmd_code == 8'h26 |=> rd_valid_q && rd_data_q == $past(mlow_q))
    else $error("margin-low read not answered");

  a_read_freq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_valid && !cmd_write && cmd_code == 8'h33 |=> rd_valid_q && rd_data_q == $past(freq_q))
    else $error("frequency read not answered");
endmodule

// >>> verification/pmr_host_model.sv
/*
  command-port host: issues one-cycle read and write commands.
  assumes the register bank takes a command at the edge after cmd_valid rises.
*/
`timescale 1ns/100ps
module pmr_host_model (
  // clock
  input wire logic clk_sys,
  // command port
  output logic cmd_valid,
  output logic cmd_write,
  output pmr_pkg::pmr_code_type cmd_code,
  output pmr_pkg::pmr_word_type cmd_wdata,
  input wire pmr_pkg::pmr_word_type rd_data,
  input wire logic rd_valid
);
  import pmr_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // ==========================================
  // one command, lines scrambled once released
  task automatic issue(input logic wr_en, input pmr_code_type code, input pmr_word_type data);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_write <= wr_en;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_write <= ~wr_en;
    cmd_code <= ~code;
    cmd_wdata <= ~data;
    #1;
  endtask

  task automatic wr(input pmr_code_type code, input pmr_word_type data);
    issue(1'b1, code, data);
  endtask

  task automatic rd(input pmr_code_type code, output pmr_word_type data, output logic seen);
    issue(1'b0, code, 16'h5a5a);
    seen = rd_valid;
    data = rd_data;
  endtask
endmodule

// >>> verification/test_pmbus_margin_freq_regs.sv
/*
  self-checking bench of the margin, divider and frequency registers.
  assumes the host model and the register bank share clk_sys.
*/
`timescale 1ns/100ps
`include "pmr_cfg.svh"
module test_pmbus_margin_freq_regs;
  import pmr_pkg::*;

  // ==========================================
  // signals
  logic clk_sys, rst_n, cmd_valid, cmd_write, rd_valid, cmd_unsupported;
  logic store_req, restore_req, store_busy, nvm_wr, margin_low_req, margin_exit;
  logic clear_faults, margin_active, cml_event, status_cml, cml_ivd;
  pmr_code_type cmd_code, nvm_code;
  pmr_word_type cmd_wdata, rd_data, nvm_data, vout_trim, vout_fb_target;
  pmr_word_type mlow_q, scale_q, freq_q;
  int failures = 0;
  int n_checks = 0;
  pmr_word_type fw [0:6] = '{16'h0008, 16'h003c, 16'h003d, 16'h0000, 16'h0021, 16'h0007, 16'h07ff};
  pmr_word_type fe [0:6] = '{16'h280a, 16'h283c, 16'h283c, 16'h2807, 16'h2826, 16'h2807, 16'h283c};
  pmr_word_type sc [0:2] = '{16'h0026, 16'h0029, 16'h0033};
  pmr_word_type sd [0:2] = '{16'h7fff, 16'hb800, 16'h283c};

  pmr_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_unsupported(cmd_unsupported), .store_req(store_req),
    .restore_req(restore_req), .store_busy(store_busy), .nvm_wr(nvm_wr),
    .nvm_code(nvm_code), .nvm_data(nvm_data), .vout_trim(vout_trim),
    .margin_low_req(margin_low_req), .margin_exit(margin_exit),
    .clear_faults(clear_faults), .margin_active(margin_active),
    .vout_fb_target(vout_fb_target), .cml_event(cml_event), .status_cml(status_cml),
    .cml_ivd(cml_ivd), .margin_low_target(mlow_q), .feedback_divider_ratio(scale_q),
    .switching_frequency_select(freq_q));

  pmr_host_model u_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================
  // helpers
  function automatic pmr_word_type b(input logic x);
    return {15'h0000, x};
  endfunction

  task automatic chk(input string name, input pmr_word_type got, input pmr_word_type exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_chk(input string name, input pmr_code_type code, input pmr_word_type exp);
    pmr_word_type d;
    logic v;
    u_host.rd(code, d, v);
    chk("read strobe", b(v), 16'h0001);
    chk(name, d, exp);
  endtask

  task automatic margin(input pmr_word_type ml, input pmr_word_type tr, input pmr_word_type fb,
    input logic cml);
    u_host.wr(`PMR_CMD_MLOW, ml);
    @(posedge clk_sys);
    vout_trim <= tr;
    margin_low_req <= 1'b1;
    @(posedge clk_sys);
    margin_low_req <= 1'b0;
    #1;
    chk("margin active", b(margin_active), 16'h0001);
    chk("fb target", vout_fb_target, fb);
    chk("cml event", b(cml_event), b(cml));
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================
  // watchdog, some thirty times the expected run
  initial begin
    #160000;
    failures++;
    conclude();
  end

  // ==========================================
  // tests
  initial begin
    pmr_word_type d;
    logic v;
    rst_n = 1'b0;
    store_req = 1'b0;
    restore_req = 1'b0;
    vout_trim = 16'h0000;
    margin_low_req = 1'b0;
    margin_exit = 1'b0;
    clear_faults = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk("mlow reset", 8'h26, 16'h0451);
    rd_chk("scale reset", 8'h29, 16'hb900);
    rd_chk("freq reset", 8'h33, 16'h2813);
    $display("test reset done");
    u_host.wr(8'h26, 16'hffff);
    rd_chk("mlow ro bit", 8'h26, 16'h7fff);
    u_host.wr(8'h29, 16'h0300);
    rd_chk("scale sat", 8'h29, 16'hba00);
    u_host.wr(8'h29, 16'h0000);
    rd_chk("scale exp", 8'h29, 16'hb800);
    u_host.rd(8'h27, d, v);
    chk("unmapped", b(cmd_unsupported), 16'h0001);
    chk("unmapped strobe", b(v), 16'h0000);
    u_host.wr(8'h27, 16'h1234);
    chk("unmapped wr", b(cmd_unsupported), 16'h0001);
    $display("test access done");
    for (int i = 0; i < 7; i++) begin
      u_host.wr(8'h33, fw[i]);
      rd_chk("freq step", 8'h33, fe[i]);
    end
    $display("test frequency done");
    @(posedge clk_sys);
    store_req <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("store busy", b(store_busy), 16'h0001);
    chk("nvm early", b(nvm_wr), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      store_req <= 1'b0;
      #1;
      chk("nvm wr", b(nvm_wr), 16'h0001);
      chk("nvm code", {8'h00, nvm_code}, sc[i]);
      chk("nvm data", nvm_data, sd[i]);
    end
    chk("store done", b(store_busy), 16'h0000);
    @(posedge clk_sys);
    #1;
    chk("nvm refused", b(nvm_wr), 16'h0000);
    $display("test store done");
    u_host.wr(8'h29, 16'h0100);
    margin(16'h0451, 16'h0000, 16'h0228, 1'b0);
    margin(16'h0451, 16'hffa0, 16'h01f8, 1'b0);
    chk("cml clean", b(status_cml), 16'h0000);
    margin(16'h0800, 16'h0000, 16'h02ff, 1'b1);
    chk("cml flag", b(status_cml), 16'h0001);
    chk("ivd flag", b(cml_ivd), 16'h0001);
    margin(16'h0100, 16'h0000, 16'h01cd, 1'b1);
    @(posedge clk_sys);
    clear_faults <= 1'b1;
    @(posedge clk_sys);
    clear_faults <= 1'b0;
    #1;
    chk("cml cleared", b(status_cml), 16'h0000);
    chk("ivd cleared", b(cml_ivd), 16'h0000);
    @(posedge clk_sys);
    clear_faults <= 1'b1;
    margin(16'h0800, 16'h0000, 16'h02ff, 1'b1);
    chk("set beats clear", b(status_cml), 16'h0001);
    chk("ivd beats clear", b(cml_ivd), 16'h0001);
    @(posedge clk_sys);
    clear_faults <= 1'b0;
    #1;
    chk("cml cleared late", b(status_cml), 16'h0000);
    u_host.wr(8'h29, 16'h0200);
    margin(16'h0258, 16'h0000, 16'h0258, 1'b0);
    @(posedge clk_sys);
    margin_exit <= 1'b1;
    @(posedge clk_sys);
    margin_exit <= 1'b0;
    #1;
    chk("margin exit", b(margin_active), 16'h0000);
    $display("test margin done");
    @(posedge clk_sys);
    restore_req <= 1'b1;
    @(posedge clk_sys);
    restore_req <= 1'b0;
    #1;
    chk("mlow restore", mlow_q, 16'h0451);
    chk("scale restore", scale_q, 16'hb900);
    chk("freq restore", freq_q, 16'h2813);
    rd_chk("freq reread", 8'h33, 16'h2813);
    $display("test restore done");
    u_host.wr(8'h26, 16'h0123);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("mlow rst", mlow_q, 16'h0451);
    chk("fb rst", vout_fb_target, 16'h0000);
    chk("busy rst", b(store_busy), 16'h0000);
    rd_chk("mlow reread", 8'h26, 16'h0451);
    $display("test mid reset done");
    conclude();
  end
endmodule
